/* File: rtl/jic_pkg.sv */
// Constants, codes and state type shared by the test port logic.
package jic_pkg;

    // ==========================================================
    // Instruction encodings
    localparam int         IR_WIDTH      = 4;
    localparam logic [3:0] INS_EXTEST    = 4'h0;
    localparam logic [3:0] INS_INTEST    = 4'h1;
    localparam logic [3:0] INS_SAMPLE    = 4'h2;
    localparam logic [3:0] INS_ABORT     = 4'h8;
    localparam logic [3:0] INS_DP_ACCESS = 4'ha;
    localparam logic [3:0] INS_AP_ACCESS = 4'hb;
    localparam logic [3:0] INS_IDCODE    = 4'he;
    localparam logic [3:0] INS_BYPASS    = 4'hf;
    // Value captured into the instruction chain, low bits 01 as the standard asks.
    localparam logic [3:0] IR_CAPTURE    = 4'h1;

    // ==========================================================
    // Data chain sizes and fixed values
    localparam int          NUM_PADS     = 8;
    localparam int          BSR_BITS_PER = 3;
    localparam int          BSR_LEN      = NUM_PADS * BSR_BITS_PER;
    localparam int          BSR_IN_POS   = 0;
    localparam int          BSR_OUT_POS  = 1;
    localparam int          BSR_OE_POS   = 2;
    localparam int          ID_LEN       = 32;
    localparam int          DBG_LEN      = 35;
    localparam int          DBG_DATA_LSB = 3;
    localparam logic        BYPASS_CAPTURE = 1'b0;
    // Arbitrary neutral identification value; bit 0 must stay 1.
    localparam logic [31:0] ID_DEFAULT   = 32'h0000_1001;

    // ==========================================================
    // Debug acknowledge codes
    localparam logic [2:0] ACK_WAIT     = 3'h1;
    localparam logic [2:0] ACK_OK_FAULT = 3'h2;

    // ==========================================================
    // Test access port controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jic_tap_state_t;

endpackage : jic_pkg

/* File: rtl/jic_test_port.sv */
// Boundary-scan test port: instruction decode, data chains and debug access handover.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for levels and toggles.
module jic_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : jic_sync

// ==========================================================
// Top of the test port.
module jic_test_port
    import jic_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = ID_DEFAULT
) (
    // System clock and reset
    input  wire logic                REF_CLK_IN,
    input  wire logic                RST_N_IN,
    // Serial test link
    input  wire logic                TCK_IN,
    input  wire logic                TMS_IN,
    input  wire logic                TDI_IN,
    output logic                     TDO_OUT,
    output logic                     TDO_OE_OUT,
    // Pad and core side of the boundary cells
    input  wire logic [NUM_PADS-1:0] PAD_IN_IN,
    input  wire logic [NUM_PADS-1:0] CORE_OUT_IN,
    input  wire logic [NUM_PADS-1:0] CORE_OE_IN,
    output logic      [NUM_PADS-1:0] PAD_OUT_OUT,
    output logic      [NUM_PADS-1:0] PAD_OE_OUT,
    output logic      [NUM_PADS-1:0] CORE_IN_OUT,
    // Debug port request side
    output logic                     DBG_REQ_OUT,
    output logic                     DBG_AP_SEL_OUT,
    output logic      [1:0]          DBG_ADDR_OUT,
    output logic                     DBG_RNW_OUT,
    output logic      [31:0]         DBG_WDATA_OUT,
    output logic                     DBG_ABORT_OUT,
    output logic      [31:0]         DBG_ABORT_DATA_OUT,
    // Debug port response side
    input  wire logic                DBG_DONE_IN,
    input  wire logic [31:0]         DBG_RDATA_IN,
    input  wire logic [2:0]          DBG_ACK_IN
);

    // ==========================================================
    // Test clock domain: controller state machine
    jic_tap_state_t state_q;
    jic_tap_state_t state_d;

    // Standard sixteen-state walk, one step per rising TCK.
    always_comb begin
        state_d = state_q;
        case (state_q)
            TAP_RESET:    state_d = TMS_IN ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     state_d = TMS_IN ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   state_d = TMS_IN ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   state_d = TMS_IN ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_d = TMS_IN ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_d = TMS_IN ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_d = TMS_IN ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_d = TMS_IN ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   state_d = TMS_IN ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   state_d = TMS_IN ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   state_d = TMS_IN ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_d = TMS_IN ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_d = TMS_IN ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_d = TMS_IN ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_d = TMS_IN ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   state_d = TMS_IN ? TAP_SEL_DR   : TAP_IDLE;
            default:      state_d = TAP_RESET;
        endcase
    end

    // Power-on reset acts on the controller directly; TCK may be stopped then.
    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= TAP_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // State strobes used by the chains.
    wire st_reset    = (state_q == TAP_RESET);
    wire st_cap_dr   = (state_q == TAP_CAP_DR);
    wire st_shift_dr = (state_q == TAP_SHIFT_DR);
    wire st_upd_dr   = (state_q == TAP_UPD_DR);
    wire st_cap_ir   = (state_q == TAP_CAP_IR);
    wire st_shift_ir = (state_q == TAP_SHIFT_IR);
    wire st_upd_ir   = (state_q == TAP_UPD_IR);

    // ==========================================================
    // Instruction chain and holding register
    logic [IR_WIDTH-1:0] ir_shift_q;
    logic [IR_WIDTH-1:0] instruction_shift_register_q;

    // The shift chain never steers anything; only the held copy does.
    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ir_shift_q <= IR_CAPTURE;
        end else if (st_cap_ir) begin
            ir_shift_q <= IR_CAPTURE;
        end else if (st_shift_ir) begin
            ir_shift_q <= {TDI_IN, ir_shift_q[IR_WIDTH-1:1]};
        end
    end

    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            instruction_shift_register_q <= INS_IDCODE;
        end else if (st_reset) begin
            instruction_shift_register_q <= INS_IDCODE;
        end else if (st_upd_ir) begin
            instruction_shift_register_q <= ir_shift_q;
        end
    end

    // Instruction decode; any code not listed falls through to bypass.
    wire [3:0] ins        = instruction_shift_register_q;
    wire       sel_extest = (ins == INS_EXTEST);
    wire       sel_intest = (ins == INS_INTEST);
    wire       sel_sample = (ins == INS_SAMPLE);
    wire       sel_abort  = (ins == INS_ABORT);
    wire       sel_dp     = (ins == INS_DP_ACCESS);
    wire       sel_ap     = (ins == INS_AP_ACCESS);
    wire       sel_id     = (ins == INS_IDCODE);
    wire       sel_bsr    = sel_extest | sel_intest | sel_sample;
    wire       sel_dbg    = sel_abort | sel_dp | sel_ap;
    wire       sel_bypass = !(sel_bsr | sel_dbg | sel_id);

    // ==========================================================
    // Boundary chain
    logic [NUM_PADS-1:0] pad_out_q;
    logic [NUM_PADS-1:0] pad_oe_q;
    logic [NUM_PADS-1:0] pad_in_s;
    logic [NUM_PADS-1:0] pad_out_s;
    logic [NUM_PADS-1:0] pad_oe_s;
    logic [BSR_LEN-1:0]  bsr_cap;
    logic [BSR_LEN-1:0]  bsr_shift_q;
    logic [BSR_LEN-1:0]  bsr_hold_q;
    logic                bsr_upd_tgl_q;

    // Pad levels come from another domain, so they are synchronised onto TCK.
    jic_sync #(.W(3 * NUM_PADS)) u_pad_sync (
        .clk_in   (TCK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     ({PAD_IN_IN, pad_out_q, pad_oe_q}),
        .q_out    ({pad_in_s, pad_out_s, pad_oe_s})
    );

    // Three cells per pad, pad 0 nearest TDO: input, output, enable.
    for (genvar i = 0; i < NUM_PADS; i++) begin : g_cells
        assign bsr_cap[BSR_BITS_PER*i+BSR_IN_POS]  = pad_in_s[i];
        assign bsr_cap[BSR_BITS_PER*i+BSR_OUT_POS] = pad_out_s[i];
        assign bsr_cap[BSR_BITS_PER*i+BSR_OE_POS]  = pad_oe_s[i];
    end

    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bsr_shift_q <= '0;
        end else if (sel_bsr && st_cap_dr) begin
            bsr_shift_q <= bsr_cap;
        end else if (sel_bsr && st_shift_dr) begin
            bsr_shift_q <= {TDI_IN, bsr_shift_q[BSR_LEN-1:1]};
        end
    end

    // The toggle tells the system side a new preload is stable to copy.
    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bsr_hold_q    <= '0;
            bsr_upd_tgl_q <= 1'b0;
        end else if (sel_bsr && st_upd_dr) begin
            bsr_hold_q    <= bsr_shift_q;
            bsr_upd_tgl_q <= !bsr_upd_tgl_q;
        end
    end

    // ==========================================================
    // Identification and bypass chains
    logic [ID_LEN-1:0] id_shift_q;
    logic              bypass_q;

    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            id_shift_q <= '0;
            bypass_q   <= BYPASS_CAPTURE;
        end else begin
            if (sel_id && st_cap_dr) begin
                id_shift_q <= {ID_VALUE[ID_LEN-1:1], 1'b1};
            end else if (sel_id && st_shift_dr) begin
                id_shift_q <= {TDI_IN, id_shift_q[ID_LEN-1:1]};
            end
            if (sel_bypass && st_cap_dr) begin
                bypass_q <= BYPASS_CAPTURE;
            end else if (sel_bypass && st_shift_dr) begin
                bypass_q <= TDI_IN;
            end
        end
    end

    // ==========================================================
    // Debug access chains, shared shift stage for all three
    logic [DBG_LEN-1:0] dbg_shift_q;
    logic [31:0]        req_data_q;
    logic [1:0]         req_addr_q;
    logic               req_rnw_q;
    logic               req_ap_q;
    logic               req_tgl_q;
    logic [31:0]        abort_data_q;
    logic               abort_tgl_q;
    logic               done_tgl_s;
    logic               done_tgl_q;
    logic [31:0]        res_data_q;
    logic [2:0]         res_ack_q;

    // The system side answers by toggling back; unequal toggles mean busy.
    jic_sync #(.W(1)) u_done_sync (
        .clk_in   (TCK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     (done_tgl_q),
        .q_out    (done_tgl_s)
    );
    wire dbg_busy = (req_tgl_q != done_tgl_s);
    // While busy the result words are still changing, so only WAIT is shown.
    wire [DBG_LEN-1:0] dbg_cap = dbg_busy ? {32'h0000_0000, ACK_WAIT} : {res_data_q, res_ack_q};

    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dbg_shift_q <= '0;
        end else if (sel_dbg && st_cap_dr) begin
            dbg_shift_q <= dbg_cap;
        end else if (sel_dbg && st_shift_dr) begin
            dbg_shift_q <= {TDI_IN, dbg_shift_q[DBG_LEN-1:1]};
        end
    end

    // A new access is launched only when the previous one has finished.
    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            req_data_q <= '0;
            req_addr_q <= '0;
            req_rnw_q  <= 1'b0;
            req_ap_q   <= 1'b0;
            req_tgl_q  <= 1'b0;
        end else if ((sel_dp || sel_ap) && st_upd_dr && !dbg_busy) begin
            req_data_q <= dbg_shift_q[DBG_LEN-1:DBG_DATA_LSB];
            req_addr_q <= dbg_shift_q[2:1];
            req_rnw_q  <= dbg_shift_q[0];
            req_ap_q   <= sel_ap;
            req_tgl_q  <= !req_tgl_q;
        end
    end

    // Abort bypasses the busy check, since it exists to end a stuck access.
    always_ff @(posedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            abort_data_q <= '0;
            abort_tgl_q  <= 1'b0;
        end else if (sel_abort && st_upd_dr) begin
            abort_data_q <= dbg_shift_q[DBG_LEN-1:DBG_DATA_LSB];
            abort_tgl_q  <= !abort_tgl_q;
        end
    end

    // ==========================================================
    // Serial output, changed on the falling TCK edge
    logic tdo_d;
    logic tdo_q;
    logic tdo_oe_q;

    assign tdo_d = st_shift_ir ? ir_shift_q[0] :
                   sel_bsr     ? bsr_shift_q[0] :
                   sel_dbg     ? dbg_shift_q[0] :
                   sel_id      ? id_shift_q[0] : bypass_q;

    always_ff @(negedge TCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= st_shift_ir | st_shift_dr;
        end
    end

    assign TDO_OUT    = tdo_q;
    assign TDO_OE_OUT = tdo_oe_q;

    // ==========================================================
    // System clock domain: mode levels and event toggles crossed in
    logic       ext_s;
    logic       int_s;
    logic       upd_tgl_s;
    logic       req_tgl_s;
    logic       abort_tgl_s;
    logic       upd_tgl_seen_q;
    logic       req_tgl_seen_q;
    logic       abort_tgl_seen_q;

    jic_sync #(.W(5)) u_sys_sync (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     ({sel_extest, sel_intest, bsr_upd_tgl_q, req_tgl_q, abort_tgl_q}),
        .q_out    ({ext_s, int_s, upd_tgl_s, req_tgl_s, abort_tgl_s})
    );

    wire upd_evt   = (upd_tgl_s != upd_tgl_seen_q);
    wire req_evt   = (req_tgl_s != req_tgl_seen_q);
    wire abort_evt = (abort_tgl_s != abort_tgl_seen_q);

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            upd_tgl_seen_q   <= 1'b0;
            req_tgl_seen_q   <= 1'b0;
            abort_tgl_seen_q <= 1'b0;
        end else begin
            upd_tgl_seen_q   <= upd_tgl_s;
            req_tgl_seen_q   <= req_tgl_s;
            abort_tgl_seen_q <= abort_tgl_s;
        end
    end

    // ==========================================================
    // Preload copy and pad multiplexing
    logic [BSR_LEN-1:0]  preload_q;
    logic [NUM_PADS-1:0] pre_in;
    logic [NUM_PADS-1:0] pre_out;
    logic [NUM_PADS-1:0] pre_oe;
    logic [NUM_PADS-1:0] core_in_q;
    logic [NUM_PADS-1:0] pad_in_r;

    // Pad pins are asynchronous to the system clock too, so the core sees them through three flops: two of synchroniser, one output register.
    jic_sync #(.W(NUM_PADS)) u_pin_sync (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     (PAD_IN_IN),
        .q_out    (pad_in_r)
    );

    // The holding word is stable for many cycles after its toggle arrives.
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            preload_q <= '0;
        end else if (upd_evt) begin
            preload_q <= bsr_hold_q;
        end
    end

    for (genvar i = 0; i < NUM_PADS; i++) begin : g_pre
        assign pre_in[i]  = preload_q[BSR_BITS_PER*i+BSR_IN_POS];
        assign pre_out[i] = preload_q[BSR_BITS_PER*i+BSR_OUT_POS];
        assign pre_oe[i]  = preload_q[BSR_BITS_PER*i+BSR_OE_POS];
    end

    // Pad drive is registered, so it lags the mode change by a few cycles.
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pad_out_q <= '0;
            pad_oe_q  <= '0;
            core_in_q <= '0;
        end else begin
            pad_out_q <= ext_s ? pre_out : CORE_OUT_IN;
            pad_oe_q  <= ext_s ? pre_oe : CORE_OE_IN;
            core_in_q <= int_s ? pre_in : pad_in_r;
        end
    end

    assign PAD_OUT_OUT = pad_out_q;
    assign PAD_OE_OUT  = pad_oe_q;
    assign CORE_IN_OUT = core_in_q;

    // ==========================================================
    // Debug request issue and result return
    logic        dbg_req_q;
    logic        dbg_ap_q;
    logic [1:0]  dbg_addr_q;
    logic        dbg_rnw_q;
    logic [31:0] dbg_wdata_q;
    logic        dbg_abort_q;
    logic [31:0] dbg_abort_data_q;

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dbg_req_q        <= 1'b0;
            dbg_ap_q         <= 1'b0;
            dbg_addr_q       <= '0;
            dbg_rnw_q        <= 1'b0;
            dbg_wdata_q      <= '0;
            dbg_abort_q      <= 1'b0;
            dbg_abort_data_q <= '0;
        end else begin
            dbg_req_q   <= req_evt;
            dbg_abort_q <= abort_evt;
            if (req_evt) begin
                dbg_ap_q    <= req_ap_q;
                dbg_addr_q  <= req_addr_q;
                dbg_rnw_q   <= req_rnw_q;
                dbg_wdata_q <= req_data_q;
            end
            if (abort_evt) begin
                dbg_abort_data_q <= abort_data_q;
            end
        end
    end

    // Result words are written in the same cycle as the toggle, which then crosses two flops, so TCK never sees them move.
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            res_data_q <= '0;
            res_ack_q  <= ACK_OK_FAULT;
            done_tgl_q <= 1'b0;
        end else if (DBG_DONE_IN) begin
            res_data_q <= DBG_RDATA_IN;
            res_ack_q  <= DBG_ACK_IN;
            done_tgl_q <= req_tgl_s;
        end
    end

    assign DBG_REQ_OUT        = dbg_req_q;
    assign DBG_AP_SEL_OUT     = dbg_ap_q;
    assign DBG_ADDR_OUT       = dbg_addr_q;
    assign DBG_RNW_OUT        = dbg_rnw_q;
    assign DBG_WDATA_OUT      = dbg_wdata_q;
    assign DBG_ABORT_OUT      = dbg_abort_q;
    assign DBG_ABORT_DATA_OUT = dbg_abort_data_q;

endmodule : jic_test_port

`default_nettype wire

/* File: tb/jic_test_port_sva.sv */
// Checker for the test port's shift enable and debug handover.
`timescale 1ns/1ps
`default_nettype none
// ========
// Watches the top ports only.
module jic_test_port_sva (
    // Clocks, reset and link
    input wire logic        REF_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        TCK_IN,
    input wire logic        TMS_IN,
    input wire logic        TDO_OE_OUT,
    // Debug handover
    input wire logic        DBG_REQ_OUT,
    input wire logic [31:0] DBG_WDATA_OUT,
    input wire logic        DBG_ABORT_OUT,
    input wire logic [31:0] DBG_ABORT_DATA_OUT
);
    // Shift enable only moves as the controller walks in and out of a shift state.
    a_oe_entry: assert property (@(posedge TCK_IN) disable iff (!RST_N_IN)
        $rose(TDO_OE_OUT) |-> !$past(TMS_IN)) else $error("shift enable rose on TMS high");
    a_oe_hold: assert property (@(posedge TCK_IN) disable iff (!RST_N_IN)
        TDO_OE_OUT && !TMS_IN |=> TDO_OE_OUT) else $error("shift enable fell on TMS low");
    a_oe_exit: assert property (@(posedge TCK_IN) disable iff (!RST_N_IN)
        TDO_OE_OUT && TMS_IN |=> !TDO_OE_OUT) else $error("shift enable held on TMS high");
    // One update gives one pulse; a scan is far longer than eight system cycles.
    a_req_one: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        DBG_REQ_OUT |=> !DBG_REQ_OUT [*8]) else $error("request pulse too long");
    a_abort_one: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        DBG_ABORT_OUT |=> !DBG_ABORT_OUT [*8]) else $error("abort pulse too long");
    a_req_excl: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !(DBG_REQ_OUT && DBG_ABORT_OUT)) else $error("request and abort together");
    a_wdata_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !DBG_REQ_OUT |-> $stable(DBG_WDATA_OUT)) else $error("write data moved");
    a_abdata_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !DBG_ABORT_OUT |-> $stable(DBG_ABORT_DATA_OUT)) else $error("abort data moved");
    c_req: cover property (@(posedge REF_CLK_IN) DBG_REQ_OUT);
    c_abort: cover property (@(posedge REF_CLK_IN) DBG_ABORT_OUT);
    c_shift: cover property (@(posedge TCK_IN) $rose(TDO_OE_OUT));
endmodule : jic_test_port_sva

bind jic_test_port jic_test_port_sva jic_test_port_sva_inst (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
    .TCK_IN(TCK_IN), .TMS_IN(TMS_IN), .TDO_OE_OUT(TDO_OE_OUT), .DBG_REQ_OUT(DBG_REQ_OUT),
    .DBG_WDATA_OUT(DBG_WDATA_OUT), .DBG_ABORT_OUT(DBG_ABORT_OUT), .DBG_ABORT_DATA_OUT(DBG_ABORT_DATA_OUT));
`default_nettype wire

/* File: tb/jic_dbg_model.sv */
// Debug port model that answers each access a few cycles later, or an all-ones write word much later.
`timescale 1ns/1ps
`default_nettype none
// ========
module jic_dbg_model
    import jic_pkg::*;
(
    // Request side
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic [31:0] wdata_in,
    // Answer side
    output logic             done_out,
    output logic      [31:0] rdata_out,
    output logic      [2:0]  ack_out
);
    logic [8:0]  cnt_q = 9'h000;
    logic [31:0] w_q = 32'h0;
    // Outside the answer cycle the lines toggle, so a stale sample never passes.
    // An all-ones write word gets a slow answer, so a pending access can be seen.
    always @(posedge clk_in) begin
        done_out <= cnt_q == 9'h001;
        rdata_out <= cnt_q == 9'h001 ? w_q ^ 32'h5a5a_a5a5 : ~rdata_out;
        ack_out <= cnt_q == 9'h001 ? ACK_OK_FAULT : ~ack_out;
        cnt_q <= req_in ? (&wdata_in ? 9'h1ff : 9'h005) : cnt_q - ((cnt_q != 9'h000) ? 9'h001 : 9'h000);
        w_q <= req_in ? wdata_in : w_q;
    end
endmodule : jic_dbg_model
`default_nettype wire

/* File: tb/jtag_instruction_and_data_chains_test.sv */
// Bench for the test port, driving the link as a tester would.
`timescale 1ns/1ps
`default_nettype none
// ========
module jtag_instruction_and_data_chains_test
    import jic_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, tck = 1'b0, tms = 1'b1, tdi = 1'b0;
    logic        tdo, req, aps, rnw, ab, done, x;
    logic [1:0]  adr;
    logic [2:0]  ack;
    logic [7:0]  pin = 8'h0, cout = 8'h0, coe = 8'h0, pout, poe, cin;
    logic [31:0] wd, abd, rd, w, seed = 32'h0001_0fa7;
    logic [63:0] r, o, p;
    int          err_total = 0, cmp_count = 0, nreq = 0, nab = 0, n0;
    jic_test_port jic_test_port_inst (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .TCK_IN(tck), .TMS_IN(tms),
        .TDI_IN(tdi), .TDO_OUT(tdo), .TDO_OE_OUT(), .PAD_IN_IN(pin), .CORE_OUT_IN(cout), .CORE_OE_IN(coe),
        .PAD_OUT_OUT(pout), .PAD_OE_OUT(poe), .CORE_IN_OUT(cin), .DBG_REQ_OUT(req), .DBG_AP_SEL_OUT(aps),
        .DBG_ADDR_OUT(adr), .DBG_RNW_OUT(rnw), .DBG_WDATA_OUT(wd), .DBG_ABORT_OUT(ab),
        .DBG_ABORT_DATA_OUT(abd), .DBG_DONE_IN(done), .DBG_RDATA_IN(rd), .DBG_ACK_IN(ack));
    jic_dbg_model jic_dbg_model_inst (.clk_in(clk), .req_in(req), .wdata_in(wd), .done_out(done),
        .rdata_out(rd), .ack_out(ack));
    // System clock; debug pulses are counted as they pass.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        nreq <= nreq + (req ? 1 : 0);
        nab <= nab + (ab ? 1 : 0);
    end
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    function automatic int len(input logic [3:0] c);
        case (c)
            INS_EXTEST, INS_INTEST, INS_SAMPLE: return BSR_LEN;
            INS_ABORT, INS_DP_ACCESS, INS_AP_ACCESS: return DBG_LEN;
            INS_IDCODE: return ID_LEN;
            default: return 1;
        endcase
    endfunction : len
    function automatic logic [7:0] pick(input logic [63:0] v, input int k);
        for (int i = 0; i < NUM_PADS; i++) pick[i] = v[BSR_BITS_PER * i + k];
    endfunction : pick
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // The link clock runs only within a transfer; TDO is read just before each rising edge.
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5 q = tdo;
        tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask : step
    task automatic tlr();
        repeat (5) step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
    endtask : tlr
    task automatic scan(input logic i, input int n, input logic [63:0] d, output logic [63:0] q);
        q = 64'h0;
        step(1'b1, 1'b0, x);
        if (i) step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
        step(1'b0, 1'b0, x);
        for (int k = 0; k < n; k++) step(k == n - 1, d[k], q[k]);
        step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
    endtask : scan
    task automatic ir(input logic [3:0] c);
        scan(1'b1, IR_WIDTH, 64'(c), o);
        chk("ir_capture", o, 64'(IR_CAPTURE));
    endtask : ir
    // Main sequence: defaults, chain lengths, debug access, boundary modes.
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        tlr();
        scan(1'b0, ID_LEN, 64'h0, o);
        chk("idcode", o, 64'(ID_DEFAULT));
        for (int c = 0; c < 16; c++) begin
            r = {rnd(), rnd()};
            ir(4'(c));
            scan(1'b0, 48, r, o);
            chk("chain", o >> len(4'(c)), r & ((64'h1 << (48 - len(4'(c)))) - 64'h1));
            if (len(4'(c)) == 1) chk("bypass_bit", o & 64'h1, 64'h0);
        end
        for (int k = 0; k < 2; k++) begin
            ir(k == 1 ? INS_AP_ACCESS : INS_DP_ACCESS);
            w = rnd();
            n0 = nreq;
            scan(1'b0, DBG_LEN, 64'({w, 3'h5}), o);
            chk("req_count", 64'(nreq - n0), 64'h1);
            chk("payload", 64'({aps, adr, rnw, wd}), 64'({k[0], 2'h2, 1'b1, w}));
            scan(1'b0, DBG_LEN, 64'h0, o);
            chk("result", o, 64'({w ^ 32'h5a5a_a5a5, ACK_OK_FAULT}));
        end
        // A slow answer keeps the access pending: capture shows WAIT and the next update is dropped.
        ir(INS_DP_ACCESS);
        scan(1'b0, DBG_LEN, 64'({32'hffff_ffff, 3'h1}), o);
        n0 = nreq;
        scan(1'b0, DBG_LEN, 64'h0, o);
        chk("wait", {o[34:0], 29'(nreq - n0)}, {32'h0, ACK_WAIT, 29'h0});
        repeat (60) @(posedge clk);
        #1 scan(1'b0, DBG_LEN, 64'h0, o);
        chk("late_result", o, 64'({~32'h5a5a_a5a5, ACK_OK_FAULT}));
        ir(INS_ABORT);
        w = rnd();
        n0 = nab;
        scan(1'b0, DBG_LEN, 64'({w, 3'h0}), o);
        chk("abort", {32'(nab - n0), abd}, {32'h1, w});
        @(posedge clk);
        #1 {coe, cout, pin} = 24'(rnd());
        ir(INS_SAMPLE);
        p = 64'(rnd());
        scan(1'b0, BSR_LEN, p, o);
        chk("sample", {pick(o, 2), pick(o, 1), pick(o, 0)}, {coe, cout, pin});
        ir(INS_EXTEST);
        chk("extest", {poe, pout}, {pick(p, 2), pick(p, 1)});
        scan(1'b0, BSR_LEN, p, o);
        chk("ext_capture", {pick(o, 2), pick(o, 1)}, {pick(p, 2), pick(p, 1)});
        ir(INS_INTEST);
        chk("intest", cin, pick(p, 0));
        ir(INS_BYPASS);
        chk("normal", {cin, poe, pout}, {pin, coe, cout});
        tlr();
        scan(1'b0, ID_LEN, 64'h0, o);
        chk("tlr_id", o, 64'(ID_DEFAULT));
        conclude();
    end
endmodule : jtag_instruction_and_data_chains_test
`default_nettype wire
